// ### verilog/boot_section_self_program_map.sv
// boot section decode and store-program sequencer
// Operation
// - 8K boot size selects boot start
// - 16K boot size selects boot start
// - 8K concurrent section below 0xC00
// - 16K concurrent section below 0x1C00
// - 8K page bits 12:6, word 5:1
// - 16K page bits 13:7, word 6:1
// - counter bit n maps pointer bit n+1
// - busy flag until re-enable command
// - enable bit clears on completion
// - eeprom write blocks flash programming
// - flash operations timed 3.7 ms (PROG_MIN_US at 100 MHz)
`timescale 1ns/1ps
module boot_section_self_program_map
#(
  parameter int PROG_CYCLES_P = boot_map_pkg::PROG_CYCLES
)
(
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic variant_16k_i,
  input wire logic boot_size_sel_hi_i,
  input wire logic boot_size_sel_lo_i,
  input wire logic [15:0] pointer_i,
  input wire logic spm_issue_i,
  input wire boot_map_pkg::spm_cmd_t spm_cmd_i,
  input wire logic eeprom_program_enable_i,
  output logic [12:0] boot_start_o,
  output logic [12:0] app_end_o,
  output logic [6:0] page_select_field_o,
  output logic [5:0] word_in_page_field_o,
  output logic byte_select_o,
  output logic in_boot_o,
  output logic in_concurrent_o,
  output logic self_program_enable_o,
  output logic concurrent_section_busy_o,
  output logic fuse_read_blocked_o,
  output logic flash_program_o
);
  import boot_map_pkg::*;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic logic [12:0] boot_start_f(input logic v16, input logic [1:0] sz);
    logic [12:0] s;
    s = v16 ? BOOT16_START_1024 : BOOT8_START_1024;
    case (sz)
      BOOT_SZ_128: s = v16 ? BOOT16_START_128 : BOOT8_START_128;
      BOOT_SZ_256: s = v16 ? BOOT16_START_256 : BOOT8_START_256;
      BOOT_SZ_512: s = v16 ? BOOT16_START_512 : BOOT8_START_512;
      default: s = v16 ? BOOT16_START_1024 : BOOT8_START_1024;
    endcase
    return s;
  endfunction : boot_start_f

  logic [12:0] boot_start_reg, boot_start_next, app_end_reg, app_end_next;
  logic [6:0] page_reg, page_next;
  logic [5:0] word_reg, word_next;
  logic byte_reg, byte_next, in_boot_reg, in_boot_next, in_conc_reg, in_conc_next;
  logic [12:0] waddr;

  always_comb
  begin
    boot_start_next = boot_start_f(variant_16k_i, {boot_size_sel_hi_i, boot_size_sel_lo_i});
    app_end_next = boot_start_next - 13'h0001;
    // word address is pointer shifted by one
    waddr = variant_16k_i ? pointer_i[13:1] : {1'b0, pointer_i[12:1]};
    if (variant_16k_i)
    begin
      page_next = pointer_i[13:PTR16_PAGE_LO];
      word_next = pointer_i[6:1] & WORD16_MASK;
    end
    else
    begin
      page_next = pointer_i[12:PTR8_PAGE_LO];
      word_next = {1'b0, pointer_i[5:1]} & WORD8_MASK;
    end
    // low pointer bit picks the byte
    byte_next = pointer_i[0];
    in_boot_next = (waddr >= boot_start_next);
    // fixed concurrent limit, boot size independent
    in_conc_next = variant_16k_i ? (waddr <= CONC16_END) : (waddr <= CONC8_END);
  end

  // ----------------------------------------
  // store-program sequencer
  // ----------------------------------------
  spm_state_t state_reg, state_next;
  logic [PROG_CNT_W-1:0] cnt_reg, cnt_next;
  logic spe_reg, spe_next, busy_reg, busy_next, blk_reg, blk_next, prog_reg, prog_next;
  logic ee_meta_reg, ee_sync_reg;
  logic accept;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    spe_next = spe_reg;
    busy_next = busy_reg;
    prog_next = 1'b0;
    // eeprom write blocks flash and fuse reads
    blk_next = ee_sync_reg;
    accept = spm_issue_i && (state_reg == ST_IDLE) && !ee_sync_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (accept)
        begin
          spe_next = 1'b1;
          if (spm_cmd_i == CMD_ERASE || spm_cmd_i == CMD_WRITE)
          begin
            cnt_next = PROG_CNT_W'(PROG_CYCLES_P - 1);
            busy_next = 1'b1;
            prog_next = 1'b1;
            state_next = ST_BUSY;
          end
          else
          begin
            if (spm_cmd_i == CMD_REENABLE)
            begin
              busy_next = 1'b0;
            end
            state_next = ST_DONE;
          end
        end
      end
      ST_BUSY:
      begin
        prog_next = 1'b1;
        if (cnt_reg == '0)
        begin
          prog_next = 1'b0;
          state_next = ST_DONE;
        end
        else
        begin
          cnt_next = cnt_reg - PROG_CNT_W'(1);
        end
      end
      ST_DONE:
      begin
        spe_next = 1'b0;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      boot_start_reg <= BOOT8_START_1024;
      app_end_reg <= CONC8_END;
      page_reg <= '0;
      word_reg <= '0;
      byte_reg <= 1'b0;
      in_boot_reg <= 1'b0;
      in_conc_reg <= 1'b0;
      state_reg <= ST_IDLE;
      cnt_reg <= '0;
      spe_reg <= 1'b0;
      busy_reg <= 1'b0;
      blk_reg <= 1'b0;
      prog_reg <= 1'b0;
      ee_meta_reg <= 1'b0;
      ee_sync_reg <= 1'b0;
    end
    else
    begin
      boot_start_reg <= boot_start_next;
      app_end_reg <= app_end_next;
      page_reg <= page_next;
      word_reg <= word_next;
      byte_reg <= byte_next;
      in_boot_reg <= in_boot_next;
      in_conc_reg <= in_conc_next;
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      spe_reg <= spe_next;
      busy_reg <= busy_next;
      blk_reg <= blk_next;
      prog_reg <= prog_next;
      ee_meta_reg <= eeprom_program_enable_i;
      ee_sync_reg <= ee_meta_reg;
    end
  end

  assign boot_start_o = boot_start_reg;
  assign app_end_o = app_end_reg;
  assign page_select_field_o = page_reg;
  assign word_in_page_field_o = word_reg;
  assign byte_select_o = byte_reg;
  assign in_boot_o = in_boot_reg;
  assign in_concurrent_o = in_conc_reg;
  assign self_program_enable_o = spe_reg;
  assign concurrent_section_busy_o = busy_reg;
  assign fuse_read_blocked_o = blk_reg;
  assign flash_program_o = prog_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);

  a_boot_start_map: assert property ($past(variant_16k_i) == VARIANT_8K &&
    $past({boot_size_sel_hi_i, boot_size_sel_lo_i}) == BOOT_SZ_128 |-> boot_start_o == 13'h0F80)
    else $error("8K boot start wrong");
  a_app_end_16k: assert property ($past(variant_16k_i) &&
    $past({boot_size_sel_hi_i, boot_size_sel_lo_i}) == BOOT_SZ_1024 |-> app_end_o == 13'h1BFF)
    else $error("16K application end wrong");
  a_conc_limit_8k: assert property (!variant_16k_i && pointer_i[12:1] == 12'hC00
    |=> !in_concurrent_o) else $error("8K concurrent limit wrong");
  a_conc_limit_16k: assert property (variant_16k_i && pointer_i[13:1] == 13'h1BFF
    |=> in_concurrent_o) else $error("16K concurrent limit wrong");
  a_page_field_8k: assert property (!variant_16k_i |=>
    page_select_field_o == $past(pointer_i[12:6]) && word_in_page_field_o[5] == 1'b0)
    else $error("8K page field wrong");
  a_page_field_16k: assert property (variant_16k_i |=>
    page_select_field_o == $past(pointer_i[13:7]) && word_in_page_field_o == $past(pointer_i[6:1]))
    else $error("16K field wrong");
  a_busy_hold: assert property ($rose(flash_program_o) |-> concurrent_section_busy_o
    throughout (flash_program_o [*8])) else $error("busy dropped early");
  a_spe_clear: assert property (!flash_program_o && $past(flash_program_o)
    |-> ##1 !self_program_enable_o) else $error("enable not cleared");
  // a start is taken only with the synced flag low, and the blocked output shows that flag
  a_eeprom_block: assert property ($rose(flash_program_o)
    |-> !fuse_read_blocked_o) else $error("flash started under eeprom write");
  a_ignore_busy: assert property (state_reg == ST_BUSY && cnt_reg > 1 && spm_issue_i
    |=> state_reg == ST_BUSY) else $error("busy command disturbed");

  c_page_write: cover property ($rose(flash_program_o));
  c_reenable: cover property ($fell(concurrent_section_busy_o));
  c_blocked: cover property (spm_issue_i && fuse_read_blocked_o);
  c_boot_hit: cover property (in_boot_o && variant_16k_i);
endmodule : boot_section_self_program_map

// ### verilog/boot_map_pkg.sv
// constants for the boot section and self-program map
package boot_map_pkg;
  // ----------------------------------------
  // variants and boot size codes
  // ----------------------------------------
  localparam logic VARIANT_8K = 1'b0;
  localparam logic VARIANT_16K = 1'b1;
  localparam logic [1:0] BOOT_SZ_128 = 2'h3;
  localparam logic [1:0] BOOT_SZ_256 = 2'h2;
  localparam logic [1:0] BOOT_SZ_512 = 2'h1;
  localparam logic [1:0] BOOT_SZ_1024 = 2'h0;
  // ----------------------------------------
  // word address limits
  // ----------------------------------------
  localparam int WADDR_W = 13;
  localparam logic [12:0] BOOT8_START_128 = 13'h0F80;
  localparam logic [12:0] BOOT8_START_256 = 13'h0F00;
  localparam logic [12:0] BOOT8_START_512 = 13'h0E00;
  localparam logic [12:0] BOOT8_START_1024 = 13'h0C00;
  localparam logic [12:0] BOOT16_START_128 = 13'h1F80;
  localparam logic [12:0] BOOT16_START_256 = 13'h1F00;
  localparam logic [12:0] BOOT16_START_512 = 13'h1E00;
  localparam logic [12:0] BOOT16_START_1024 = 13'h1C00;
  localparam logic [12:0] FLASH8_END = 13'h0FFF;
  localparam logic [12:0] FLASH16_END = 13'h1FFF;
  localparam logic [12:0] CONC8_END = 13'h0BFF;
  localparam logic [12:0] CONC16_END = 13'h1BFF;
  localparam logic [7:0] CONC8_PAGES = 8'h60;
  localparam logic [7:0] CONC16_PAGES = 8'h70;
  // ----------------------------------------
  // pointer field positions
  // ----------------------------------------
  localparam int PTR8_PAGE_LO = 6;
  localparam int PTR16_PAGE_LO = 7;
  localparam logic [5:0] WORD8_MASK = 6'h1F;
  localparam logic [5:0] WORD16_MASK = 6'h3F;
  // ----------------------------------------
  // operation timing
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int PROG_MIN_US = 3700;
  localparam int PROG_MAX_US = 4500;
  localparam int PROG_CYCLES = PROG_MIN_US * CLK_MHZ;
  localparam int PROG_CNT_W = 20;
  // ----------------------------------------
  // command kinds and sequencer states
  // ----------------------------------------
  typedef enum logic [1:0]
  {
    CMD_FILL = 2'b00,
    CMD_ERASE = 2'b01,
    CMD_WRITE = 2'b10,
    CMD_REENABLE = 2'b11
  } spm_cmd_t;
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b10
  } spm_state_t;
endpackage : boot_map_pkg

// ### verif/spm_cpu_model.sv
// cpu-side model issuing store-program commands
`timescale 1ns/1ps
module spm_cpu_model
(
  input wire logic mclk_i,
  input wire logic self_program_enable_i,
  input wire logic eeprom_program_enable_i,
  output logic spm_issue_o,
  output boot_map_pkg::spm_cmd_t spm_cmd_o,
  output logic [15:0] pointer_o
);
  import boot_map_pkg::*;
  // ----
  // command issue
  // ----
  initial
  begin
    spm_issue_o = 1'b0;
    spm_cmd_o = CMD_FILL;
    pointer_o = 16'h0000;
  end
  task automatic put(input logic [15:0] p);
    @(posedge mclk_i);
    pointer_o <= p;
  endtask : put
  // no wait here, so callers can aim a command at a busy sequencer
  task automatic pulse(input spm_cmd_t c, input logic [15:0] p);
    @(posedge mclk_i);
    // no interrupt can split this pulse
    spm_issue_o <= 1'b1;
    spm_cmd_o <= c;
    pointer_o <= p & 16'hFFFE;
    @(posedge mclk_i);
    spm_issue_o <= 1'b0;
    #1;
  endtask : pulse
  task automatic run(input spm_cmd_t c, input logic [15:0] p);
    while (self_program_enable_i !== 1'b0)
    begin
      @(posedge mclk_i);
      #1;
    end
    while (eeprom_program_enable_i !== 1'b0)
    begin
      @(posedge mclk_i);
      #1;
    end
    pulse(c, p);
  endtask : run
endmodule : spm_cpu_model

// ### verif/boot_section_self_program_map_tb_top.sv
// self-checking bench for the boot map block
`timescale 1ns/1ps
module boot_section_self_program_map_tb_top;
  import boot_map_pkg::*;
  // ----
  // harness
  // ----
  localparam int P = 20;
  logic mclk_i, rst_b_i, variant_16k_i, boot_size_sel_hi_i, boot_size_sel_lo_i;
  logic eeprom_program_enable_i, spm_issue_i, byte_select_o, in_boot_o, in_concurrent_o;
  logic self_program_enable_o, concurrent_section_busy_o, fuse_read_blocked_o, flash_program_o;
  logic [15:0] pointer_i;
  spm_cmd_t spm_cmd_i;
  logic [12:0] boot_start_o, app_end_o;
  logic [6:0] page_select_field_o;
  logic [5:0] word_in_page_field_o;
  int mismatches, checked;
  boot_section_self_program_map #(.PROG_CYCLES_P(P)) uut (.mclk_i, .rst_b_i, .variant_16k_i,
    .boot_size_sel_hi_i, .boot_size_sel_lo_i, .pointer_i, .spm_issue_i, .spm_cmd_i,
    .eeprom_program_enable_i, .boot_start_o, .app_end_o, .page_select_field_o,
    .word_in_page_field_o, .byte_select_o, .in_boot_o, .in_concurrent_o,
    .self_program_enable_o, .concurrent_section_busy_o, .fuse_read_blocked_o, .flash_program_o);
  spm_cpu_model cpu (.mclk_i, .self_program_enable_i(self_program_enable_o),
    .eeprom_program_enable_i, .spm_issue_o(spm_issue_i), .spm_cmd_o(spm_cmd_i),
    .pointer_o(pointer_i));
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic step(input int k);
    repeat (k) @(posedge mclk_i);
    #1;
  endtask : step
  task automatic cfg(input int v, input int c, input logic [15:0] p);
    @(posedge mclk_i);
    variant_16k_i <= v[0];
    boot_size_sel_hi_i <= c[1];
    boot_size_sel_lo_i <= c[0];
    cpu.put(p);
    step(1);
  endtask : cfg
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results
  // ----
  // scenarios
  // ----
  task automatic t_boot;
    int st;
    for (int v = 0; v < 2; v++)
    begin
      for (int c = 0; c < 4; c++)
      begin
        st = (v == 1 ? 8192 : 4096) - (128 << (3 - c));
        cfg(v, c, 16'(st * 2));
        chk("boot_start", boot_start_o, 16'(st));
        chk("app_end", app_end_o, 16'(st - 1));
        chk("in_boot", in_boot_o, 16'h1);
        cfg(v, c, 16'(st * 2 - 2));
        chk("in_boot", in_boot_o, 16'h0);
      end
    end
  endtask : t_boot
  task automatic t_fields;
    logic [15:0] pt [3];
    logic [15:0] p;
    int ce;
    pt = '{16'hFFFF, 16'hA5A4, 16'h5A5B};
    for (int v = 0; v < 2; v++)
    begin
      ce = v == 1 ? 16'h1BFF : 16'h0BFF;
      cfg(v, 0, 16'(ce * 2));
      chk("in_conc", in_concurrent_o, 16'h1);
      cfg(v, 0, 16'(ce * 2 + 2));
      chk("in_conc", in_concurrent_o, 16'h0);
      for (int i = 0; i < 3; i++)
      begin
        p = pt[i];
        cfg(v, 0, p);
        chk("page", page_select_field_o, v == 1 ? p[13:7] : p[12:6]);
        chk("word", word_in_page_field_o, v == 1 ? p[6:1] : {1'b0, p[5:1]});
        chk("byte", byte_select_o, p[0]);
      end
    end
  endtask : t_fields
  task automatic t_write;
    int n;
    cpu.run(CMD_WRITE, 16'h0080);
    chk("spe", self_program_enable_o, 16'h1);
    chk("busy", concurrent_section_busy_o, 16'h1);
    n = 0;
    while (flash_program_o === 1'b1 && n < 1000)
    begin
      step(1);
      n++;
    end
    chk("prog_len", 16'(n), 16'(P));
    step(1);
    chk("spe", self_program_enable_o, 16'h0);
    chk("busy", concurrent_section_busy_o, 16'h1);
    cpu.run(CMD_REENABLE, 16'h0000);
    chk("busy", concurrent_section_busy_o, 16'h0);
    step(1);
    chk("spe", self_program_enable_o, 16'h0);
  endtask : t_write
  task automatic t_drop;
    int n;
    cpu.run(CMD_ERASE, 16'h0040);
    cpu.pulse(CMD_REENABLE, 16'h0000);
    n = 0;
    while (self_program_enable_o === 1'b1 && n < 1000)
    begin
      step(1);
      n++;
    end
    chk("spe_len", 16'(n), 16'(P - 1));
    step(2);
    chk("busy", concurrent_section_busy_o, 16'h1);
    chk("prog", flash_program_o, 16'h0);
    cpu.run(CMD_REENABLE, 16'h0000);
    cpu.run(CMD_FILL, 16'h0002);
    chk("spe", self_program_enable_o, 16'h1);
    chk("prog", flash_program_o, 16'h0);
    step(1);
    chk("spe", self_program_enable_o, 16'h0);
  endtask : t_drop
  task automatic t_eeprom;
    @(posedge mclk_i);
    eeprom_program_enable_i <= 1'b1;
    step(4);
    chk("fuse_blk", fuse_read_blocked_o, 16'h1);
    cpu.pulse(CMD_ERASE, 16'h0000);
    step(1);
    chk("spe", self_program_enable_o, 16'h0);
    chk("prog", flash_program_o, 16'h0);
    @(posedge mclk_i);
    eeprom_program_enable_i <= 1'b0;
    step(4);
    chk("fuse_blk", fuse_read_blocked_o, 16'h0);
  endtask : t_eeprom
  // ----
  // clock, sequence, watchdog
  // ----
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial
  begin
    rst_b_i = 1'b0;
    variant_16k_i = 1'b0;
    boot_size_sel_hi_i = 1'b0;
    boot_size_sel_lo_i = 1'b0;
    eeprom_program_enable_i = 1'b0;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    step(1);
    chk("boot_start", boot_start_o, 16'h0C00);
    chk("app_end", app_end_o, 16'h0BFF);
    t_boot;
    t_fields;
    t_write;
    t_drop;
    t_eeprom;
    results;
  end
  // whole run is well under 2000 cycles
  initial
  begin
    #300000;
    mismatches++;
    results;
  end
endmodule : boot_section_self_program_map_tb_top
